// ---- design/crre_pkg.sv ----
// package for the call, return and rotate execution block
package crre_pkg;
    // opcode fields
    localparam logic [3:0] OP_REL_CALL_PFX = 4'hD;
    localparam logic [3:0] OP_ROT_C_HI = 4'h3;
    localparam logic [3:0] OP_ROT_N_HI = 4'h4;
    localparam logic [1:0] ROT_LEFT_SEL = 2'h1;
    localparam logic [1:0] ROT_RIGHT_SEL = 2'h0;
    localparam logic [7:0] OP_LITRET_HI = 8'h0C;
    localparam logic [15:0] OP_SWRESET = 16'h00FF;
    localparam logic [15:0] OP_PUSH = 16'h0005;
    localparam logic [15:0] OP_POP = 16'h0006;
    localparam logic [14:0] OP_IRET_HI = 15'h0008;
    localparam logic [14:0] OP_SRET_HI = 15'h0009;
    // program counter and stack
    localparam int PC_W = 21;
    localparam logic [20:0] PC_STEP = 21'h000002;
    localparam logic [20:0] PC_RESET = 21'h000000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [2:0] STAT_RESET = 3'h0;
    // flag positions inside the 3-bit flag group
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;

    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_IDLE = 2'b10
    } crre_state_e;

    typedef enum logic [1:0] {
        STK_NONE = 2'h0,
        STK_PUSH = 2'h1,
        STK_POP = 2'h2
    } crre_stack_op_e;

    // architectural context loaded or restored
    typedef struct packed {
        logic [7:0] accum;
        logic [2:0] flags;
        logic [7:0] bank;
    } crre_ctx_s;

    // write-back of a rotate result to the file register
    typedef struct packed {
        logic valid;
        logic accessBank;
        logic [7:0] addr;
        logic [7:0] data;
    } crre_fwr_s;
endpackage

// ---- design/crre_rotate.sv ----
// rotate unit for the four rotate operations
`timescale 1ns/1ps
`default_nettype none
module crre_rotate
    import crre_pkg::*;
(
    // operand
    input wire logic [7:0] operand,
    input wire logic carryIn,
    input wire logic toLeft,
    input wire logic thruCarry,
    // result
    output logic [7:0] result,
    output logic [2:0] flagsOut,
    output logic carryTouched
);
    logic inBit;
    always_comb begin
        if (toLeft) begin
            inBit = thruCarry ? carryIn : operand[7];
            result = {operand[6:0], inBit};
            flagsOut[FLG_C] = thruCarry ? operand[7] : carryIn;
        end else begin
            inBit = thruCarry ? carryIn : operand[0];
            result = {inBit, operand[7:1]};
            flagsOut[FLG_C] = thruCarry ? operand[0] : carryIn;
        end
        flagsOut[FLG_Z] = (result == BYTE_ZERO);
        flagsOut[FLG_N] = result[7];
        carryTouched = thruCarry;
    end
endmodule // crre_rotate
`default_nettype wire

// ---- design/crre_exec.sv ----
// execution logic for call, return, reset, stack and rotate instructions
// Notes on behaviour
// - push places pc plus 2 on stack top, old top moves down
// - pop discards stack top, previous entry becomes top
// - relative call: prefix 11011 then 11-bit signed word offset
// - relative call pushes pc plus 2, jumps to pc plus 2 plus 2n
// - relative call takes two cycles, second one idle
// - software reset opcode requests the master clear reset
// - interrupt return pops stack and loads pc from stack top
// - interrupt return sets high or low global irq enable
// - shadow bit 1 restores accumulator, flags, bank; 0 leaves them
// - literal return loads literal to accumulator and pc from stack
// - returns leave pc upper and high latches unchanged
// - subroutine return pops into pc, flags untouched unless shadow
// - rotate left through carry updates carry, negative, zero
// - rotate left plain updates negative and zero only
// - rotate right through carry updates carry, negative, zero
// - rotate right plain updates negative and zero only
`timescale 1ns/1ps
`default_nettype none
module crre_exec
    import crre_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // instruction issue
    input wire logic instrValid,
    input wire logic [15:0] instrWord,
    input wire logic [PC_W-1:0] pcNow,
    // core state inputs
    input wire logic [PC_W-1:0] stackTopEntry,
    input wire crre_ctx_s ctxNow,
    input wire crre_ctx_s shadowCtx,
    input wire logic [7:0] fileOperand,
    input wire logic irqHighPriMode,
    // stack control
    output logic [1:0] stackOp,
    output logic [PC_W-1:0] stackPushValue,
    // program counter
    output logic pcLoad,
    output logic [PC_W-1:0] pcValue,
    // context write
    output logic accumLoad,
    output logic flagsLoad,
    output logic bankLoad,
    output crre_ctx_s ctxOut,
    output crre_fwr_s fileWrite,
    // interrupt enables and reset
    output logic globalHighIrqEnableSet,
    output logic globalLowIrqEnableSet,
    output logic masterClearReset,
    output logic busy
);
    typedef struct packed {
        crre_state_e state;
        logic [1:0] stackOp;
        logic [PC_W-1:0] pushVal;
        logic pcLoad;
        logic [PC_W-1:0] pcValue;
        logic accumLoad;
        logic flagsLoad;
        logic bankLoad;
        crre_ctx_s ctx;
        crre_fwr_s fwr;
        logic hiSet;
        logic loSet;
        logic rstReq;
        logic busy;
    } crre_st_s;

    crre_st_s state_reg;
    crre_st_s state_next;
    logic [7:0] rotResult;
    logic [2:0] rotFlags;
    logic rotCarryUsed;
    logic [PC_W-1:0] pcInc;
    logic [PC_W-1:0] relOffset;
    logic shadowBit;
    logic isCall;
    logic isPush;
    logic isPop;
    logic isSwReset;
    logic isIntRet;
    logic isSubRet;
    logic isLitRet;
    logic isRotate;

    assign pcInc = pcNow + PC_STEP;
    // sign-extended offset times two
    assign relOffset = {{(PC_W-12){instrWord[10]}}, instrWord[10:0], 1'b0};
    assign shadowBit = instrWord[0];
    // opcode decode
    assign isCall = (instrWord[15:12] == OP_REL_CALL_PFX) && instrWord[11];
    assign isPush = (instrWord == OP_PUSH);
    assign isPop = (instrWord == OP_POP);
    assign isSwReset = (instrWord == OP_SWRESET);
    assign isIntRet = (instrWord[15:1] == OP_IRET_HI);
    assign isSubRet = (instrWord[15:1] == OP_SRET_HI);
    assign isLitRet = (instrWord[15:8] == OP_LITRET_HI);
    assign isRotate = (instrWord[15:12] == OP_ROT_C_HI || instrWord[15:12] == OP_ROT_N_HI) &&
        (instrWord[11:10] == ROT_LEFT_SEL || instrWord[11:10] == ROT_RIGHT_SEL);

    crre_rotate u_rot (
        .operand(fileOperand),
        .carryIn(ctxNow.flags[FLG_C]),
        .toLeft(instrWord[11:10] == ROT_LEFT_SEL),
        .thruCarry(instrWord[15:12] == OP_ROT_C_HI),
        .result(rotResult),
        .flagsOut(rotFlags),
        .carryTouched(rotCarryUsed)
    );

    always_comb begin
        state_next = state_reg;
        state_next.stackOp = STK_NONE;
        state_next.pcLoad = 1'b0;
        state_next.accumLoad = 1'b0;
        state_next.flagsLoad = 1'b0;
        state_next.bankLoad = 1'b0;
        state_next.fwr.valid = 1'b0;
        state_next.hiSet = 1'b0;
        state_next.loSet = 1'b0;
        state_next.rstReq = 1'b0;
        unique case (state_reg.state)
            ST_IDLE: begin
                state_next.state = ST_RUN;
            end
            ST_RUN: begin
                if (instrValid) begin
                    if (isCall) begin
                        state_next.stackOp = STK_PUSH;
                        state_next.pushVal = pcInc;
                        state_next.pcLoad = 1'b1;
                        state_next.pcValue = pcInc + relOffset;
                        state_next.state = ST_IDLE;
                    end else if (isPush) begin
                        state_next.stackOp = STK_PUSH;
                        state_next.pushVal = pcInc;
                    end else if (isPop) begin
                        state_next.stackOp = STK_POP;
                    end else if (isSwReset) begin
                        state_next.rstReq = 1'b1;
                    end else if (isIntRet || isSubRet) begin
                        state_next.stackOp = STK_POP;
                        state_next.pcLoad = 1'b1;
                        state_next.pcValue = stackTopEntry;
                        if (isIntRet) begin
                            state_next.hiSet = irqHighPriMode;
                            state_next.loSet = ~irqHighPriMode;
                        end
                        state_next.accumLoad = shadowBit;
                        state_next.flagsLoad = shadowBit;
                        state_next.bankLoad = shadowBit;
                        state_next.ctx = shadowCtx;
                        state_next.state = ST_IDLE;
                    end else if (isLitRet) begin
                        state_next.stackOp = STK_POP;
                        state_next.pcLoad = 1'b1;
                        state_next.pcValue = stackTopEntry;
                        state_next.accumLoad = 1'b1;
                        state_next.ctx.accum = instrWord[7:0];
                        state_next.state = ST_IDLE;
                    end else if (isRotate) begin
                        state_next.flagsLoad = 1'b1;
                        state_next.ctx.flags = rotFlags;
                        if (!rotCarryUsed) begin
                            state_next.ctx.flags[FLG_C] = ctxNow.flags[FLG_C];
                        end
                        if (instrWord[9]) begin
                            state_next.fwr.valid = 1'b1;
                            state_next.fwr.accessBank = ~instrWord[8];
                            state_next.fwr.addr = instrWord[7:0];
                            state_next.fwr.data = rotResult;
                        end else begin
                            state_next.accumLoad = 1'b1;
                            state_next.ctx.accum = rotResult;
                        end
                    end
                end
            end
        endcase
        state_next.busy = (state_next.state == ST_IDLE);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= '{
                state: ST_RUN,
                stackOp: STK_NONE,
                pushVal: PC_RESET,
                pcLoad: 1'b0,
                pcValue: PC_RESET,
                accumLoad: 1'b0,
                flagsLoad: 1'b0,
                bankLoad: 1'b0,
                ctx: '{accum: BYTE_ZERO, flags: STAT_RESET, bank: BYTE_ZERO},
                fwr: '{valid: 1'b0, accessBank: 1'b0, addr: BYTE_ZERO, data: BYTE_ZERO},
                hiSet: 1'b0,
                loSet: 1'b0,
                rstReq: 1'b0,
                busy: 1'b0
            };
        end else begin
            state_reg <= state_next;
        end
    end

    assign stackOp = state_reg.stackOp;
    assign stackPushValue = state_reg.pushVal;
    assign pcLoad = state_reg.pcLoad;
    assign pcValue = state_reg.pcValue;
    assign accumLoad = state_reg.accumLoad;
    assign flagsLoad = state_reg.flagsLoad;
    assign bankLoad = state_reg.bankLoad;
    assign ctxOut = state_reg.ctx;
    assign fileWrite = state_reg.fwr;
    assign globalHighIrqEnableSet = state_reg.hiSet;
    assign globalLowIrqEnableSet = state_reg.loSet;
    assign masterClearReset = state_reg.rstReq;
    assign busy = state_reg.busy;
endmodule // crre_exec
`default_nettype wire

// ---- verification/crre_exec_props.sv ----
// property checker for the call, return and rotate execution block
`timescale 1ns/1ps
`default_nettype none
module crre_exec_props
    import crre_pkg::*;
(
    // issue side
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic instrValid,
    input wire logic [15:0] instrWord,
    input wire logic [PC_W-1:0] pcNow,
    input wire logic [PC_W-1:0] stackTopEntry,
    input wire crre_ctx_s ctxNow,
    input wire crre_ctx_s shadowCtx,
    input wire logic [7:0] fileOperand,
    input wire logic irqHighPriMode,
    // result side
    input wire logic [1:0] stackOp,
    input wire logic [PC_W-1:0] stackPushValue,
    input wire logic pcLoad,
    input wire logic [PC_W-1:0] pcValue,
    input wire logic accumLoad,
    input wire logic flagsLoad,
    input wire logic bankLoad,
    input wire crre_ctx_s ctxOut,
    input wire crre_fwr_s fileWrite,
    input wire logic globalHighIrqEnableSet,
    input wire logic globalLowIrqEnableSet,
    input wire logic masterClearReset,
    input wire logic busy
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic take;
    assign take = instrValid && !busy;
    sequence call_in; take && instrWord[15:11] == {OP_REL_CALL_PFX, 1'h1}; endsequence
    sequence ret_in; take && instrWord[15:2] == OP_IRET_HI[14:1]; endsequence
    sequence idle_out; busy ##1 !busy && stackOp == STK_NONE && !pcLoad; endsequence
    sequence rotl_in; take && instrWord[15:10] == {OP_ROT_C_HI, ROT_LEFT_SEL}; endsequence
    a_call_push: assert property (call_in |=> stackOp == STK_PUSH
        && stackPushValue == $past(pcNow) + PC_STEP) else $error("call push wrong");
    a_call_target: assert property (call_in |=> pcLoad && pcValue == $past(pcNow)
        + PC_STEP + {{9{$past(instrWord[10])}}, $past(instrWord[10:0]), 1'h0})
        else $error("call target wrong");
    a_call_idle: assert property (call_in |=> idle_out)
        else $error("call not two cycles");
    a_ret_idle: assert property (ret_in |=> idle_out)
        else $error("return not two cycles");
    a_ret_pop: assert property (ret_in |=> stackOp == STK_POP && pcLoad
        && pcValue == $past(stackTopEntry)) else $error("return pop wrong");
    a_iret_enable: assert property (take && instrWord[15:1] == OP_IRET_HI |=>
        globalHighIrqEnableSet == $past(irqHighPriMode)
        && globalLowIrqEnableSet != $past(irqHighPriMode)) else $error("enable set wrong");
    a_shadow_sel: assert property (ret_in |=>
        {accumLoad, flagsLoad, bankLoad} == {3{$past(instrWord[0])}}
        && (!accumLoad || ctxOut == $past(shadowCtx))) else $error("shadow restore wrong");
    a_litret_load: assert property (take && instrWord[15:8] == OP_LITRET_HI |=>
        accumLoad && !flagsLoad && ctxOut.accum == $past(instrWord[7:0])
        && pcValue == $past(stackTopEntry)) else $error("literal return wrong");
    a_swreset_req: assert property (take && instrWord == OP_SWRESET |=>
        masterClearReset && !busy) else $error("reset request missing");
    a_rotl_carry: assert property (rotl_in
        |=> flagsLoad && ctxOut.flags[FLG_C] == $past(fileOperand[7])
        && (fileWrite.valid ? fileWrite.data : ctxOut.accum)
        == {$past(fileOperand[6:0]), $past(ctxNow.flags[FLG_C])}) else $error("rotate wrong");
endmodule // crre_exec_props
bind crre_exec crre_exec_props u_props (.*);
`default_nettype wire

// ---- verification/tb_top.sv ----
// testbench for the call, return and rotate execution block
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import crre_pkg::*;
;
    logic clk_sys, rst, instrValid, irqHighPriMode, pcLoad, accumLoad, flagsLoad, bankLoad;
    logic globalHighIrqEnableSet, globalLowIrqEnableSet, masterClearReset, busy;
    logic [15:0] instrWord;
    logic [PC_W-1:0] pcNow, stackTopEntry, stackPushValue, pcValue;
    crre_ctx_s ctxNow, shadowCtx, ctxOut;
    crre_fwr_s fileWrite;
    logic [7:0] fileOperand;
    logic [1:0] stackOp;
    int errCount, nTests;
    crre_exec uut (.*);
    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        nTests++;
        if (got !== exp) begin
            errCount++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic issue(input logic [15:0] w);
        // valid held up between calls
        instrValid = 1'h1;
        instrWord = w;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic t_misc;
        pcNow = 21'h000124;
        issue(OP_PUSH);
        chk("push top", {STK_PUSH, 21'h000126}, {stackOp, stackPushValue});
        issue(OP_POP);
        chk("pop kind", STK_POP, stackOp);
        issue(OP_SWRESET);
        chk("reset req", 1'h1, masterClearReset);
    endtask
    task automatic t_call;
        logic [10:0] n;
        for (int i = 0; i < 2; i++) begin
            n = i[0] ? 11'h3FF : 11'h400;
            issue({5'h1B, n});
            chk("call push", {STK_PUSH, 21'h000126}, {stackOp, stackPushValue});
            chk("call pc", 21'h000126 + {{9{n[10]}}, n, 1'h0}, pcValue);
            chk("call busy", {1'h1, 1'h1}, {pcLoad, busy});
            issue(OP_PUSH);
            chk("call idle", 3'h0, {stackOp, busy});
        end
    endtask
    task automatic t_ret;
        logic s, lit;
        logic [PC_W-1:0] top;
        for (int i = 0; i < 5; i++) begin
            s = i < 4 && i[0];
            lit = i == 4;
            irqHighPriMode = i[0];
            top = 21'h014332 + i[20:0];
            stackTopEntry = top;
            issue(lit ? 16'h0C5A : 16'h0010 + i[15:0]);
            chk("ret pop", {STK_POP, top}, {stackOp, pcValue});
            chk("hi set", i < 2 && i[0], globalHighIrqEnableSet);
            chk("lo set", i < 2 && !i[0], globalLowIrqEnableSet);
            chk("ctx loads", {s || lit, s}, {accumLoad, bankLoad});
            chk("flags load", s, flagsLoad);
            if (s) chk("shadow", shadowCtx, ctxOut);
            if (lit) chk("literal", 8'h5A, ctxOut.accum);
            chk("ret busy", 1'h1, busy);
            @(posedge clk_sys);
            #1;
            chk("ret idle", 2'h0, {busy, pcLoad});
        end
    endtask
    task automatic t_rot;
        logic [7:0] op, r, rv;
        logic [3:0] ef;
        logic [15:0] w;
        logic c, cn, d, pl, rt;
        for (int i = 0; i < 32; i++) begin
            pl = i[0];
            rt = i[1];
            c = i[2];
            d = i[3];
            op = i[4] ? 8'h81 : 8'h00;
            r = rt ? {pl ? op[0] : c, op[7:1]} : {op[6:0], pl ? op[7] : c};
            cn = pl ? c : (rt ? op[0] : op[7]);
            ef = {1'h1, r[7], r == 8'h00, cn};
            fileOperand = op;
            ctxNow.flags = {2'h0, c};
            w = {pl ? OP_ROT_N_HI : OP_ROT_C_HI, rt ? ROT_RIGHT_SEL : ROT_LEFT_SEL, d, c, 8'h3C};
            issue(w);
            rv = d ? fileWrite.data : ctxOut.accum;
            chk("rot flags", ef, {flagsLoad, ctxOut.flags});
            chk("rot dest", {d, !d}, {fileWrite.valid, accumLoad});
            chk("rot result", r, rv);
            if (d) chk("rot bank", !c, fileWrite.accessBank);
            if (d) chk("rot addr", 8'h3C, fileWrite.addr);
        end
    endtask
    initial begin
        rst = 1'h1;
        instrValid = 1'h0;
        instrWord = 16'h0000;
        pcNow = 21'h000124;
        stackTopEntry = 21'h000000;
        ctxNow = {8'h11, 3'h0, 8'h22};
        shadowCtx = {8'hC3, 3'h5, 8'h07};
        fileOperand = 8'h00;
        irqHighPriMode = 1'h0;
        repeat (6) @(posedge clk_sys);
        #1;
        rst = 1'h0;
        chk("reset busy", 3'h0, {busy, stackOp});
        t_misc;
        t_call;
        t_ret;
        t_rot;
        give_verdict;
    end
    initial begin
        #20000;
        errCount++;
        give_verdict;
    end
endmodule // tb_top
`default_nettype wire
